// >>> hdl/imls_meas.sv
// load-current measurement sequencer: each start pulse begins a conversion, restarting any still in progress
// assumes per-rail currents already digitised, 11 bits, 20 mA per code step
module imls_meas (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic start,
   input wire logic [1:0] rail_sel,
   input wire logic [3:0] is_slave,
   input wire logic [3:0][1:0] master_of,
   input wire logic [3:0][10:0] rail_cur,
   output logic [10:0] result,
   output logic done
);
   imls_pkg::imls_state_e state;
   logic [4:0] cnt;
   logic [1:0] rail;
   logic [12:0] sum;
   always_comb
   begin
      sum = 13'h0000;
      // a master gathers every slave pointed at it; a slave reports only itself
      if (is_slave[rail])
      begin
         sum = {2'b00, rail_cur[rail]};
      end
      else
      begin
         for (int i = 0; i < 4; i++)
         begin
            if (i == int'(rail) || (is_slave[i] && master_of[i] == rail))
            begin
               sum = sum + {2'b00, rail_cur[i]};
            end
         end
      end
   end
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         state <= imls_pkg::IMLS_IDLE;
         cnt <= 5'h00;
         rail <= 2'h0;
         result <= 11'h000;
         done <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         // a new start restarts the conversion, so writes made during one yield a single result
         if (start)
         begin
            state <= imls_pkg::IMLS_CONV;
            rail <= rail_sel;
            cnt <= 5'(imls_pkg::MEAS_CYCLES - 1);
         end
         else
         begin
            unique case (state)
               imls_pkg::IMLS_IDLE: ;
               imls_pkg::IMLS_CONV:
               begin
                  if (cnt == 5'h00)
                  begin
                     state <= imls_pkg::IMLS_DONE;
                  end
                  else
                  begin
                     cnt <= cnt - 5'h01;
                  end
               end
               imls_pkg::IMLS_DONE:
               begin
                  // saturate at full code
                  result <= (sum > 13'h07FF) ? 11'h7FF : sum[10:0];
                  done <= 1'b1;
                  state <= imls_pkg::IMLS_IDLE;
               end
               default: state <= imls_pkg::IMLS_IDLE;
            endcase
         end
      end
   end
endmodule

// >>> hdl/imls_pkg.sv
// package for the rail interrupt mask and load-measurement select block
// assumes a byte-wide register port decoded by an upstream serial-interface slave
package imls_pkg;
   localparam logic [7:0] ADDR_TOP_EVENT_MASK_TWO = 8'h22;
   localparam logic [7:0] ADDR_RAIL01_MASK = 8'h23;
   localparam logic [7:0] ADDR_RAIL23_MASK = 8'h24;
   localparam logic [7:0] ADDR_LOAD_SEL = 8'h25;
   localparam logic [7:0] ADDR_LOAD_HI = 8'h26;
   localparam logic [7:0] ADDR_LOAD_LO = 8'h27;
   localparam logic [7:0] ADDR_INT_FLAGS = 8'h30;
   localparam logic [7:0] ADDR_INT_MASK1 = 8'h31;
   localparam logic [7:0] ADDR_INT_FLAGS_HI = 8'h32;
   localparam int BIT_RESET_REG_MASK = 0;
   localparam int BIT_OC_LO = 0;
   localparam int BIT_PG_LO = 2;
   localparam int BIT_OC_HI = 4;
   localparam int BIT_PG_HI = 6;
   localparam int BIT_READY_MASK = 0;
   localparam logic [7:0] RST_TOP_EVENT_MASK_TWO = 8'h00;
   localparam logic [7:0] RST_RAIL_MASK = 8'h00;
   localparam logic [7:0] RST_LOAD_SEL = 8'h00;
   localparam logic [7:0] RST_MASK1 = 8'h00;
   localparam logic [7:0] RAIL_MASK_WMASK = 8'h55;
   localparam int MEAS_CYCLES = 16;
   localparam int CUR_W = 11;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } imls_bus_s;
   typedef enum logic [1:0] {
      IMLS_IDLE = 2'b00,
      IMLS_CONV = 2'b01,
      IMLS_DONE = 2'b10
   } imls_state_e;
endpackage

// >>> hdl/imls_top.sv
// interrupt masks, latched flags and load-current measurement select
// assumes the serial slave hands over one-cycle byte reads and writes on mclk
module imls_top (
   input wire logic mclk,
   input wire logic resetn,
   input wire imls_pkg::imls_bus_s bus,
   output logic [7:0] rdata,
   input wire logic [3:0] pg_pin,
   input wire logic [3:0] oc_pin,
   input wire logic reset_reg_event,
   input wire logic [3:0] is_slave,
   input wire logic [3:0][1:0] master_of,
   input wire logic [3:0][10:0] rail_cur,
   output logic [3:0] powergood_raw,
   output logic [3:0] overcurrent_raw,
   output logic irq_out_n
);
   logic [7:0] top_event_mask_two;
   logic [7:0] rail01_event_mask;
   logic [7:0] rail23_event_mask;
   logic [7:0] load_meas_select;
   logic [7:0] top_mask_one;
   logic [3:0] pg_s1, pg_s2, pg_s3, oc_s1, oc_s2, oc_s3;
   logic [9:0] flags;
   logic [9:0] flag_en;
   logic [9:0] flag_set;
   logic meas_start;
   logic meas_done;
   logic [10:0] meas_result;
   logic [7:0] next_rdata;
   wire wr_sel = bus.wr && bus.addr == imls_pkg::ADDR_LOAD_SEL;

   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         top_event_mask_two <= imls_pkg::RST_TOP_EVENT_MASK_TWO;
         rail01_event_mask <= imls_pkg::RST_RAIL_MASK;
         rail23_event_mask <= imls_pkg::RST_RAIL_MASK;
         load_meas_select <= imls_pkg::RST_LOAD_SEL;
         top_mask_one <= imls_pkg::RST_MASK1;
      end
      else if (bus.wr)
      begin
         unique case (bus.addr)
            imls_pkg::ADDR_TOP_EVENT_MASK_TWO: top_event_mask_two <= bus.wdata;
            // odd bits read-only zero
            imls_pkg::ADDR_RAIL01_MASK:
               rail01_event_mask <= bus.wdata & imls_pkg::RAIL_MASK_WMASK;
            imls_pkg::ADDR_RAIL23_MASK:
               rail23_event_mask <= bus.wdata & imls_pkg::RAIL_MASK_WMASK;
            imls_pkg::ADDR_LOAD_SEL: load_meas_select <= bus.wdata;
            imls_pkg::ADDR_INT_MASK1: top_mask_one <= bus.wdata;
            default: ;
         endcase
      end
   end

   // any write to the select register starts a conversion, even a same-value one
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         meas_start <= 1'b0;
      end
      else
      begin
         meas_start <= wr_sel;
      end
   end

   imls_meas u_meas (
      .mclk(mclk),
      .resetn(resetn),
      .start(meas_start),
      .rail_sel(load_meas_select[1:0]),
      .is_slave(is_slave),
      .master_of(master_of),
      .rail_cur(rail_cur),
      .result(meas_result),
      .done(meas_done)
   );

   // three-stage synchronisers; raw status ignores the masks entirely
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         pg_s1 <= 4'h0;
         pg_s2 <= 4'h0;
         pg_s3 <= 4'h0;
         oc_s1 <= 4'h0;
         oc_s2 <= 4'h0;
         oc_s3 <= 4'h0;
         powergood_raw <= 4'h0;
         overcurrent_raw <= 4'h0;
      end
      else
      begin
         pg_s1 <= pg_pin;
         pg_s2 <= pg_s1;
         pg_s3 <= pg_s2;
         oc_s1 <= oc_pin;
         oc_s2 <= oc_s1;
         oc_s3 <= oc_s2;
         for (int i = 0; i < 4; i++)
         begin
            if (pg_s2[i] == pg_s3[i])
            begin
               powergood_raw[i] <= pg_s3[i];
            end
            if (oc_s2[i] == oc_s3[i])
            begin
               overcurrent_raw[i] <= oc_s3[i];
            end
         end
      end
   end

   // flag order: 0 oc0,1 pg0,2 oc1,3 pg1,4 oc2,5 pg2,6 oc3,7 pg3,8 reset_reg,9 ready
   always_comb
   begin
      flag_set = 10'h000;
      for (int i = 0; i < 4; i++)
      begin
         // pg flags on any edge of the filtered level, oc on rising edge
         flag_set[2 * i] = (oc_s2[i] == oc_s3[i]) && oc_s3[i] && !overcurrent_raw[i];
         flag_set[2 * i + 1] = (pg_s2[i] == pg_s3[i]) && (pg_s3[i] != powergood_raw[i]);
      end
      flag_set[8] = reset_reg_event;
      flag_set[9] = meas_done;
      flag_en = ~{top_mask_one[imls_pkg::BIT_READY_MASK],
                  top_event_mask_two[imls_pkg::BIT_RESET_REG_MASK],
                  rail23_event_mask[imls_pkg::BIT_PG_HI], rail23_event_mask[imls_pkg::BIT_OC_HI],
                  rail23_event_mask[imls_pkg::BIT_PG_LO], rail23_event_mask[imls_pkg::BIT_OC_LO],
                  rail01_event_mask[imls_pkg::BIT_PG_HI], rail01_event_mask[imls_pkg::BIT_OC_HI],
                  rail01_event_mask[imls_pkg::BIT_PG_LO], rail01_event_mask[imls_pkg::BIT_OC_LO]};
   end

   // write-one-to-clear; a set in the same cycle wins
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         flags <= 10'h000;
      end
      else
      begin
         for (int i = 0; i < 10; i++)
         begin
            if (flag_set[i])
            begin
               flags[i] <= 1'b1;
            end
            else if (bus.wr && bus.addr == imls_pkg::ADDR_INT_FLAGS + 8'(i / 8)
                     && bus.wdata[i % 8])
            begin
               flags[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         irq_out_n <= 1'b1;
      end
      else
      begin
         irq_out_n <= ~|(flags & flag_en);
      end
   end

   always_comb
   begin
      unique case (bus.addr)
         imls_pkg::ADDR_TOP_EVENT_MASK_TWO: next_rdata = top_event_mask_two;
         imls_pkg::ADDR_RAIL01_MASK: next_rdata = rail01_event_mask;
         imls_pkg::ADDR_RAIL23_MASK: next_rdata = rail23_event_mask;
         imls_pkg::ADDR_LOAD_SEL: next_rdata = load_meas_select;
         imls_pkg::ADDR_LOAD_HI: next_rdata = {5'h00, meas_result[10:8]};
         imls_pkg::ADDR_LOAD_LO: next_rdata = meas_result[7:0];
         imls_pkg::ADDR_INT_FLAGS: next_rdata = flags[7:0];
         imls_pkg::ADDR_INT_MASK1: next_rdata = top_mask_one;
         imls_pkg::ADDR_INT_FLAGS_HI: next_rdata = {6'h00, flags[9:8]};
         default: next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         rdata <= 8'h00;
      end
      else if (bus.rd)
      begin
         rdata <= next_rdata;
      end
   end

   a_start_one_cycle: assert property (@(posedge mclk) disable iff (!resetn)
      wr_sel |=> meas_start ##1 (u_meas.state == imls_pkg::IMLS_CONV))
      else $error("select write did not give one start pulse");
   a_irq_follows_flags: assert property (@(posedge mclk) disable iff (!resetn)
      |(flags & flag_en) |=> !irq_out_n)
      else $error("unmasked flag did not assert interrupt");
   a_irq_clear: assert property (@(posedge mclk) disable iff (!resetn)
      !(|(flags & flag_en)) |=> irq_out_n)
      else $error("interrupt stayed asserted with no unmasked flag");
   a_reset_mask: assert property (@(posedge mclk) disable iff (!resetn)
      top_event_mask_two[0] && flags[8] && !(|(flags[9:0] & ~10'h100 & flag_en))
      |=> irq_out_n)
      else $error("masked reset-register flag drove interrupt");
   a_meas_ready: assert property (@(posedge mclk) disable iff (!resetn)
      meas_done |=> flags[9])
      else $error("measurement done did not set ready flag");
   a_meas_bounded: assert property (@(posedge mclk) disable iff (!resetn)
      meas_start ##1 !meas_start [*8] |-> ##[1:12] meas_done)
      else $error("measurement never completed");
   a_raw_unmasked: assert property (@(posedge mclk) disable iff (!resetn)
      (pg_s2[0] == pg_s3[0]) |=> powergood_raw[0] == $past(pg_s3[0]))
      else $error("raw power-good not tracking input");
   a_mask_reserved: assert property (@(posedge mclk) disable iff (!resetn)
      (rail01_event_mask & ~imls_pkg::RAIL_MASK_WMASK) == 8'h00)
      else $error("read-only mask bits became set");
endmodule

// >>> tb/imls_host.sv
// host model: issues byte register cycles on the decoded register port
// assumes one caller process; every change lands just after a rising mclk
module imls_host (
   input wire logic mclk,
   input wire logic [7:0] rdata,
   output imls_pkg::imls_bus_s bus
);
   timeunit 1ns;
   timeprecision 1ps;
   initial bus = '0;
   // rel low leaves the request up so the next call follows back to back
   task automatic write(input logic [7:0] a, input logic [7:0] d, input logic rel);
      @(posedge mclk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      if (rel)
      begin
         @(posedge mclk);
         bus <= '0;
      end
   endtask
   task automatic read(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge mclk);
      bus <= '0;
      @(posedge mclk);
      d = rdata;
   endtask
endmodule

// >>> tb/imls_tb_top.sv
// bench for the interrupt mask and load-measurement select block
// assumes imls_host drives the register port; rail status is driven here
module imls_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [7:0] a;
      logic [7:0] w;
      logic [7:0] e;
   } imls_row_s;
   localparam imls_row_s ROWS [6] = '{'{8'h22, 8'hff, 8'hff}, '{8'h23, 8'hff, 8'h55},
      '{8'h24, 8'hff, 8'h55}, '{8'h24, 8'haa, 8'h00}, '{8'h40, 8'hff, 8'h00},
      '{8'h22, 8'h00, 8'h00}};
   localparam logic [10:0] MEAS [4] = '{11'h12c, 11'h0c8, 11'h7ff, 11'h7f0};
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic reset_reg_event = 1'b0;
   logic [3:0] pg_pin = 4'h0;
   logic [3:0] oc_pin = 4'h0;
   // rail 1 follows rail 0, rail 3 follows rail 2; rail 2 sum saturates
   logic [3:0] is_slave = 4'ha;
   logic [3:0][1:0] master_of = 8'ha0;
   logic [3:0][10:0] rail_cur = {11'h7f0, 11'h12c, 11'h0c8, 11'h064};
   imls_pkg::imls_bus_s bus;
   logic [7:0] rdata;
   logic [3:0] powergood_raw;
   logic [3:0] overcurrent_raw;
   logic irq_out_n;
   logic [7:0] a;
   logic [7:0] m;
   int fails = 0;
   int samples_checked = 0;
   int cyc = 0;
   imls_top i_imls_top (.mclk(mclk), .resetn(resetn), .bus(bus), .rdata(rdata),
      .pg_pin(pg_pin), .oc_pin(oc_pin), .reset_reg_event(reset_reg_event),
      .is_slave(is_slave), .master_of(master_of), .rail_cur(rail_cur),
      .powergood_raw(powergood_raw), .overcurrent_raw(overcurrent_raw),
      .irq_out_n(irq_out_n));
   imls_host i_imls_host (.mclk(mclk), .rdata(rdata), .bus(bus));
   initial forever #5 mclk = ~mclk;
   task automatic test_done();
      $display("compares %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fails++;
         test_done();
      end
   end
   task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_pin(input string n, input logic e, input logic g);
      samples_checked++;
      if (g !== e)
      begin
         fails++;
         $display("CHECK FAILED %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic rd_chk(input logic [7:0] ad, input logic [7:0] e);
      logic [7:0] d;
      i_imls_host.read(ad, d);
      chk_reg("rdata", e, d);
   endtask
   task automatic irq_is(input logic e);
      for (int i = 0; i < 64 && irq_out_n !== e; i++)
         @(posedge mclk);
      chk_pin("irq_out_n", e, irq_out_n);
   endtask
   // k even is a rail overcurrent input, k odd its power-good input
   task automatic pin(input int k, input logic v);
      @(posedge mclk);
      if (k % 2)
         pg_pin[k / 2] <= v;
      else
         oc_pin[k / 2] <= v;
      @(posedge mclk);
      for (int i = 0; i < 64 && {powergood_raw, overcurrent_raw} !== {pg_pin, oc_pin}; i++)
         @(posedge mclk);
      chk_reg("raw status", {pg_pin, oc_pin}, {powergood_raw, overcurrent_raw});
      repeat (4) @(posedge mclk);
   endtask
   initial
   begin
      repeat (3) @(posedge mclk);
      resetn <= 1'b1;
      chk_pin("irq_out_n", 1'b1, irq_out_n);
      foreach (ROWS[i])
      begin
         i_imls_host.write(ROWS[i].a, ROWS[i].w, 1'b1);
         rd_chk(ROWS[i].a, ROWS[i].e);
      end
      // a reset in mid-conversion must clear masks and drop the result
      i_imls_host.write(8'h23, 8'hff, 1'b1);
      i_imls_host.write(8'h25, 8'h03, 1'b1);
      @(posedge mclk);
      resetn <= 1'b0;
      repeat (3) @(posedge mclk);
      resetn <= 1'b1;
      for (int i = 0; i < 6; i++)
         rd_chk(8'h22 + 8'(i), 8'h00);
      repeat (30) @(posedge mclk);
      chk_pin("irq_out_n", 1'b1, irq_out_n);
      for (int k = 0; k < 8; k++)
      begin
         a = (k < 4) ? 8'h23 : 8'h24;
         m = 8'h01 << (((k % 4) / 2) * 4 + (k % 2) * 2);
         i_imls_host.write(a, m, 1'b1);
         pin(k, 1'b1);
         chk_pin("irq_out_n", 1'b1, irq_out_n);
         pin(k, 1'b0);
         i_imls_host.write(8'h30, 8'hff, 1'b1);
         i_imls_host.write(a, 8'h00, 1'b1);
         pin(k, 1'b1);
         irq_is(1'b0);
         rd_chk(8'h30, 8'h01 << k);
         pin(k, 1'b0);
         i_imls_host.write(8'h30, 8'hff, 1'b1);
         irq_is(1'b1);
      end
      for (int s = 0; s < 4; s++)
      begin
         i_imls_host.write(8'h25, 8'(s), 1'b1);
         irq_is(1'b0);
         rd_chk(8'h26, {5'h00, MEAS[s][10:8]});
         rd_chk(8'h27, MEAS[s][7:0]);
         rd_chk(8'h25, 8'(s));
         i_imls_host.write(8'h31, 8'h02, 1'b1);
         irq_is(1'b1);
      end
      // back to back: the second write restarts, so one result for rail 2
      i_imls_host.write(8'h25, 8'h01, 1'b0);
      i_imls_host.write(8'h25, 8'hfe, 1'b1);
      irq_is(1'b0);
      rd_chk(8'h27, 8'hff);
      i_imls_host.write(8'h31, 8'h02, 1'b1);
      repeat (40) @(posedge mclk);
      chk_pin("irq_out_n", 1'b1, irq_out_n);
      i_imls_host.write(8'h31, 8'h01, 1'b1);
      i_imls_host.write(8'h25, 8'h00, 1'b1);
      repeat (30) @(posedge mclk);
      chk_pin("irq_out_n", 1'b1, irq_out_n);
      rd_chk(8'h32, 8'h02);
      i_imls_host.write(8'h31, 8'h02, 1'b1);
      i_imls_host.write(8'h22, 8'h01, 1'b1);
      @(posedge mclk);
      reset_reg_event <= 1'b1;
      @(posedge mclk);
      reset_reg_event <= 1'b0;
      repeat (8) @(posedge mclk);
      chk_pin("irq_out_n", 1'b1, irq_out_n);
      rd_chk(8'h32, 8'h01);
      i_imls_host.write(8'h31, 8'h01, 1'b1);
      i_imls_host.write(8'h22, 8'h00, 1'b1);
      @(posedge mclk);
      reset_reg_event <= 1'b1;
      @(posedge mclk);
      reset_reg_event <= 1'b0;
      irq_is(1'b0);
      i_imls_host.write(8'h31, 8'h01, 1'b1);
      irq_is(1'b1);
      test_done();
   end
endmodule
